// ### design/isv_vectoring.sv
// interrupt source collection and vector assignment for the core
//
// Contract
// - table entries map local inputs to vectors
// - controller disabled: input0 maskable, input1 nmi
// - maskable request fetches vector from controller
// - nmi input serviced with vector 2
// - vectors 0,5,6,7 fault; 3,4 trap; no code
// - vector 8 abort with zero error code
// - vectors 10 to 14 fault with code
// - vector 17 fault with zero code
// - vectors 16 and 19 fault, no code
// - vector 18 abort, code implementation defined
// - 9, 15, 20-31 reserved; 32-255 user
// - request path 0-255, local path 16-255
// - interrupt enable flag blocks all maskable
// - local vectors 0-15 flagged illegal
// - software interrupt accepts any vector
// - soft vector 2 skips nmi hardware state
// - software interrupts ignore enable flag
// - side-band pins bypass this vectoring
// - vector range 0-255, 0-31 architectural
`timescale 1ns/10ps

module isv_vectoring
    import isv_pkg::*;
(
    input  wire logic       SYS_CLK_I,        // core clock, 125 MHz
    input  wire logic       RST_N_I,          // async reset, active low
    input  wire logic [1:0] LOCAL_INT_I,      // local interrupt pins, async
    input  wire logic       LIC_EN_I,         // local controller enabled (hardware)
    input  wire isv_vtab_t  VTAB0_I,          // table entry for local input 0
    input  wire isv_vtab_t  VTAB1_I,          // table entry for local input 1
    input  wire logic       ROUTER_VALID_I,   // router vector message valid
    input  wire logic [7:0] ROUTER_VEC_I,     // router vector number
    output logic            ROUTER_READY_O,   // router message accepted
    output logic            INTA_REQ_O,       // bus vector fetch request
    input  wire logic       INTA_ACK_I,       // bus vector fetch complete
    input  wire logic [7:0] INTA_VEC_I,       // vector from external controller
    input  wire logic       INT_ENABLE_I,     // interrupt enable flag of the flags word
    input  wire logic       SOFT_REQ_I,       // software interrupt instruction
    input  wire logic [7:0] SOFT_VEC_I,       // its vector operand
    input  wire logic       EXC_REQ_I,        // architectural exception raised
    input  wire logic [7:0] EXC_VEC_I,        // its vector
    input  wire logic       NMI_DONE_I,       // nmi handler returned
    input  wire logic       CORE_READY_I,     // core takes the event
    output logic            EVT_VALID_O,      // event pending towards core
    output isv_event_t      EVT_O,            // event details
    output logic            ILLEGAL_VEC_O,    // pulse: local vector 0-15 received
    output logic            RSVD_VEC_O,       // pulse: reserved exception vector dropped
    output logic            NMI_ACTIVE_O      // nmi hardware handling state
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
        end else begin
            pin_meta <= LOCAL_INT_I;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ----------------------------------------
    // source routing
    // ----------------------------------------
    logic [1:0] pin_rise;
    logic       raw_nmi;
    logic       raw_mreq;
    logic [1:0] vtab_fire;
    logic [1:0] vtab_nmi;
    isv_vtab_t  vtab [2];

    assign vtab[0]  = VTAB0_I;
    assign vtab[1]  = VTAB1_I;
    assign pin_rise = pin_sync & ~pin_prev;

    // per-pin table programming while controller is enabled
    for (genvar g = 0; g < 2; g++) begin : g_vtab
        assign vtab_fire[g] = LIC_EN_I && pin_rise[g] && !vtab[g].masked;
        assign vtab_nmi[g]  = vtab_fire[g] && vtab[g].nmi_mode;
    end

    // hardware-disabled: fixed pin roles; maskable request is level sensitive
    assign raw_mreq = !LIC_EN_I && pin_sync[0];
    assign raw_nmi  = (!LIC_EN_I && pin_rise[1]) || (|vtab_nmi);

    // ----------------------------------------
    // pending state
    // ----------------------------------------
    logic       nmi_pend;
    logic       loc_pend;
    logic [7:0] loc_vec;
    logic       accept;
    isv_event_t next_evt;
    logic       next_valid;
    logic       loc_msg;
    logic [7:0] loc_msg_vec;
    logic       loc_take;

    // table fixed-mode vector wins over a router message in the same cycle
    always_comb begin
        loc_msg     = 1'b0;
        loc_msg_vec = ROUTER_VEC_I;
        if (vtab_fire[0] && !vtab[0].nmi_mode) begin
            loc_msg     = 1'b1;
            loc_msg_vec = vtab[0].vector;
        end else if (vtab_fire[1] && !vtab[1].nmi_mode) begin
            loc_msg     = 1'b1;
            loc_msg_vec = vtab[1].vector;
        end else if (ROUTER_VALID_I) begin
            loc_msg     = 1'b1;
        end
    end

    assign ROUTER_READY_O = !loc_pend && !(vtab_fire[0] && !vtab[0].nmi_mode)
                            && !(vtab_fire[1] && !vtab[1].nmi_mode);
    assign loc_take       = loc_msg && !loc_pend && loc_msg_vec >= VEC_LOCAL_MIN;
    assign accept         = EVT_VALID_O && CORE_READY_I;

    // nmi latch: edge held until delivered, set wins over clear
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            nmi_pend <= 1'b0;
        end else if (raw_nmi) begin
            nmi_pend <= 1'b1;
        end else if (accept && EVT_O.source == ISV_SRC_NMI) begin
            nmi_pend <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            loc_pend <= 1'b0;
            loc_vec  <= 8'h00;
        end else if (loc_take) begin
            loc_pend <= 1'b1;
            loc_vec  <= loc_msg_vec;
        end else if (accept && EVT_O.source == ISV_SRC_LOCAL) begin
            loc_pend <= 1'b0;
        end
    end

    // illegal local vector reported, message discarded
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ILLEGAL_VEC_O <= 1'b0;
        end else begin
            ILLEGAL_VEC_O <= loc_msg && !loc_pend && loc_msg_vec < VEC_LOCAL_MIN;
        end
    end

    // ----------------------------------------
    // maskable request vector fetch
    // ----------------------------------------
    logic       mreq_pend;
    logic [7:0] mreq_vec;

    // request held until controller answers; any of 0-255 accepted
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INTA_REQ_O <= 1'b0;
            mreq_pend  <= 1'b0;
            mreq_vec   <= 8'h00;
        end else if (INTA_REQ_O) begin
            if (INTA_ACK_I) begin
                INTA_REQ_O <= 1'b0;
                mreq_pend  <= 1'b1;
                mreq_vec   <= INTA_VEC_I;
            end
        end else if (mreq_pend) begin
            if (accept && EVT_O.source == ISV_SRC_MASKABLE) begin
                mreq_pend <= 1'b0;
            end
        end else if (raw_mreq && INT_ENABLE_I) begin
            INTA_REQ_O <= 1'b1;
        end
    end

    // ----------------------------------------
    // classification of a vector
    // ----------------------------------------
    function automatic isv_event_t classify(input logic [7:0] v);
        isv_event_t e;
        e          = '0;
        e.vector   = v;
        e.cls      = ISV_CLS_INTERRUPT;
        case (v)
            VEC_DIVIDE_ERROR, VEC_BOUND_RANGE,
            VEC_INVALID_OPCODE, VEC_COPROC_UNAVAIL: e.cls = ISV_CLS_FAULT;
            VEC_BREAKPOINT, VEC_OVERFLOW:           e.cls = ISV_CLS_TRAP;
            VEC_DOUBLE_FAULT: begin
                e.cls      = ISV_CLS_ABORT;
                e.push_err = 1'b1;
                e.err_zero = 1'b1;
            end
            VEC_ALIGN_CHECK: begin
                e.cls      = ISV_CLS_FAULT;
                e.push_err = 1'b1;
                e.err_zero = 1'b1;
            end
            VEC_X87_MATH, VEC_SIMD_FLOAT:           e.cls = ISV_CLS_FAULT;
            VEC_MACHINE_CHECK: begin
                e.cls      = ISV_CLS_ABORT;
                e.push_err = MC_PUSHES_ERRCODE;
            end
            default: begin
                if (v >= VEC_ERRCODE_LO && v <= VEC_ERRCODE_HI) begin
                    e.cls      = ISV_CLS_FAULT;
                    e.push_err = 1'b1;
                end
            end
        endcase
        return e;
    endfunction

    // 9, 15 and 20-31 raised as hardware exceptions are dropped and flagged on RSVD_VEC_O
    logic exc_rsvd;
    assign exc_rsvd = EXC_VEC_I == VEC_RSVD_09 || EXC_VEC_I == VEC_RSVD_0F
                      || (EXC_VEC_I > VEC_SIMD_FLOAT && EXC_VEC_I <= VEC_RSVD_HI);

    // ----------------------------------------
    // priority selection
    // ----------------------------------------
    // order: exception, nmi, software, local, maskable request.
    // side-band pins (reset, flush, stop clock, mgmt, init) have no input here.
    always_comb begin
        next_valid = 1'b0;
        next_evt   = '0;
        if (EXC_REQ_I && !exc_rsvd) begin
            next_valid        = 1'b1;
            next_evt          = classify(EXC_VEC_I);
            next_evt.source   = ISV_SRC_EXCEPTION;
        end else if (nmi_pend && !NMI_ACTIVE_O) begin
            next_valid        = 1'b1;
            next_evt.source   = ISV_SRC_NMI;
            next_evt.vector   = VEC_NMI;
            next_evt.cls      = ISV_CLS_INTERRUPT;
            next_evt.nmi_hw   = 1'b1;
        end else if (SOFT_REQ_I) begin
            // no error code even for vectors that normally carry one
            next_valid        = 1'b1;
            next_evt.source   = ISV_SRC_SOFT;
            next_evt.vector   = SOFT_VEC_I;
            next_evt.cls      = ISV_CLS_INTERRUPT;
            next_evt.nmi_hw   = 1'b0;
        end else if (loc_pend && INT_ENABLE_I) begin
            next_valid        = 1'b1;
            next_evt.source   = ISV_SRC_LOCAL;
            next_evt.vector   = loc_vec;
            next_evt.cls      = ISV_CLS_INTERRUPT;
        end else if (mreq_pend && INT_ENABLE_I) begin
            next_valid        = 1'b1;
            next_evt.source   = ISV_SRC_MASKABLE;
            next_evt.vector   = mreq_vec;
            next_evt.cls      = ISV_CLS_INTERRUPT;
        end
    end

    // output register reloads only when empty or taken, so data stays stable while stalled
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            EVT_VALID_O <= 1'b0;
            EVT_O       <= '0;
        end else if (!EVT_VALID_O || CORE_READY_I) begin
            EVT_VALID_O <= next_valid && !(accept && next_evt.source == EVT_O.source
                                            && EVT_O.source != ISV_SRC_EXCEPTION
                                            && EVT_O.source != ISV_SRC_SOFT);
            EVT_O       <= next_evt;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RSVD_VEC_O <= 1'b0;
        end else begin
            RSVD_VEC_O <= EXC_REQ_I && exc_rsvd;
        end
    end

    // nmi hardware state: blocks further nmi until handler returns
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            NMI_ACTIVE_O <= 1'b0;
        end else if (accept && EVT_O.nmi_hw) begin
            NMI_ACTIVE_O <= 1'b1;
        end else if (NMI_DONE_I) begin
            NMI_ACTIVE_O <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_nmi_vec;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        EVT_VALID_O && EVT_O.source == ISV_SRC_NMI |-> EVT_O.vector == VEC_NMI && EVT_O.nmi_hw;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi event without vector 2");

    property p_soft_no_nmi_hw;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        EVT_VALID_O && EVT_O.source == ISV_SRC_SOFT |-> !EVT_O.nmi_hw && !EVT_O.push_err;
    endproperty
    a_soft_no_nmi_hw: assert property (p_soft_no_nmi_hw) else $error("soft event marked nmi");

    property p_mask_gate;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !INT_ENABLE_I && (!EVT_VALID_O || CORE_READY_I) |=> !(EVT_VALID_O
            && (EVT_O.source == ISV_SRC_LOCAL || EVT_O.source == ISV_SRC_MASKABLE));
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("maskable event while disabled");

    property p_local_range;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        EVT_VALID_O && EVT_O.source == ISV_SRC_LOCAL |-> EVT_O.vector >= VEC_LOCAL_MIN;
    endproperty
    a_local_range: assert property (p_local_range) else $error("local vector below 16");

    property p_illegal;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        loc_msg && !loc_pend && loc_msg_vec < VEC_LOCAL_MIN |=> ILLEGAL_VEC_O && !loc_pend;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal local vector not flagged");

    property p_df_code;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        EVT_VALID_O && EVT_O.vector == VEC_DOUBLE_FAULT && EVT_O.source == ISV_SRC_EXCEPTION
            |-> EVT_O.cls == ISV_CLS_ABORT && EVT_O.push_err && EVT_O.err_zero;
    endproperty
    a_df_code: assert property (p_df_code) else $error("double fault class wrong");

    property p_errcode_faults;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        EVT_VALID_O && EVT_O.source == ISV_SRC_EXCEPTION && EVT_O.vector >= VEC_ERRCODE_LO
            && EVT_O.vector <= VEC_ERRCODE_HI |-> EVT_O.cls == ISV_CLS_FAULT && EVT_O.push_err;
    endproperty
    a_errcode_faults: assert property (p_errcode_faults) else $error("vectors 10-14 wrong");

    property p_mreq_fetch;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        INTA_REQ_O && INTA_ACK_I |=> !INTA_REQ_O && mreq_pend && mreq_vec == $past(INTA_VEC_I);
    endproperty
    a_mreq_fetch: assert property (p_mreq_fetch) else $error("fetched vector not held");

    property p_nmi_pin;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !LIC_EN_I && pin_sync[1] && !pin_prev[1] |=> nmi_pend;
    endproperty
    a_nmi_pin: assert property (p_nmi_pin) else $error("nmi pin edge lost");

    c_nmi:  cover property (@(posedge SYS_CLK_I) accept && EVT_O.source == ISV_SRC_NMI);
    c_soft2: cover property (@(posedge SYS_CLK_I) accept && EVT_O.source == ISV_SRC_SOFT
                             && EVT_O.vector == VEC_NMI);
    c_mreq: cover property (@(posedge SYS_CLK_I) accept && EVT_O.source == ISV_SRC_MASKABLE);
    c_ill:  cover property (@(posedge SYS_CLK_I) ILLEGAL_VEC_O);

endmodule

// ### inc/isv_pkg.sv
// package: vector map, source codes and carrier types for the interrupt vectoring front end
package isv_pkg;

    // ----------------------------------------
    // vector numbers
    // ----------------------------------------
    localparam logic [7:0] VEC_DIVIDE_ERROR   = 8'h00;
    localparam logic [7:0] VEC_NMI            = 8'h02;
    localparam logic [7:0] VEC_BREAKPOINT     = 8'h03;
    localparam logic [7:0] VEC_OVERFLOW       = 8'h04;
    localparam logic [7:0] VEC_BOUND_RANGE    = 8'h05;
    localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
    localparam logic [7:0] VEC_COPROC_UNAVAIL = 8'h07;
    localparam logic [7:0] VEC_DOUBLE_FAULT   = 8'h08;
    localparam logic [7:0] VEC_RSVD_09        = 8'h09;
    localparam logic [7:0] VEC_ERRCODE_LO     = 8'h0A;
    localparam logic [7:0] VEC_ERRCODE_HI     = 8'h0E;
    localparam logic [7:0] VEC_RSVD_0F        = 8'h0F;
    localparam logic [7:0] VEC_X87_MATH       = 8'h10;
    localparam logic [7:0] VEC_ALIGN_CHECK    = 8'h11;
    localparam logic [7:0] VEC_MACHINE_CHECK  = 8'h12;
    localparam logic [7:0] VEC_SIMD_FLOAT     = 8'h13;
    localparam logic [7:0] VEC_RSVD_HI        = 8'h1F;
    localparam logic [7:0] VEC_LOCAL_MIN      = 8'h10;
    localparam logic [7:0] VEC_USER_MIN       = 8'h20;

    // machine check error code presence is implementation choice
    localparam logic       MC_PUSHES_ERRCODE  = 1'b0;

    // ----------------------------------------
    // local vector table entry fields
    // ----------------------------------------
    localparam int         VTAB_VEC_LSB       = 0;
    localparam int         VTAB_MASK_BIT      = 8;
    localparam int         VTAB_NMI_BIT       = 9;

    typedef enum logic [1:0] {
        ISV_CLS_FAULT,
        ISV_CLS_TRAP,
        ISV_CLS_ABORT,
        ISV_CLS_INTERRUPT
    } isv_class_t;

    typedef enum logic [2:0] {
        ISV_SRC_NONE,
        ISV_SRC_NMI,
        ISV_SRC_SOFT,
        ISV_SRC_LOCAL,
        ISV_SRC_MASKABLE,
        ISV_SRC_EXCEPTION
    } isv_source_t;

    // one table entry: nmi mode, mask, vector
    typedef struct packed {
        logic       nmi_mode;
        logic       masked;
        logic [7:0] vector;
    } isv_vtab_t;

    // delivered event towards the core
    typedef struct packed {
        isv_source_t source;
        logic [7:0]  vector;
        isv_class_t  cls;
        logic        push_err;
        logic        err_zero;
        logic        nmi_hw;
    } isv_event_t;

endpackage

// ### tb/isv_ctrl_model.sv
// partner: vector-supplying interrupt controller and io router
`timescale 1ns/10ps

module isv_ctrl_model (
    input  wire logic       clk_i,      // core clock
    input  wire logic       rst_n_i,    // reset, active low
    input  wire logic       inta_req_i, // fetch request
    input  wire logic       ready_i,    // router message taken
    input  wire logic [7:0] vec_i,      // vector to supply
    input  wire logic [3:0] wait_i,     // cycles before ack
    output logic            ack_o,      // fetch done
    output logic [7:0]      ack_vec_o,  // fetched vector
    output logic            valid_o,    // router message valid
    output logic [7:0]      msg_o       // router vector
);
    logic [3:0] cnt;

    initial begin
        valid_o = 1'b0;
        msg_o = 8'h00;
    end

    // bus toggles when not acking, so a stale vector never matches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
            ack_o <= 1'b0;
            ack_vec_o <= 8'h00;
        end else if (inta_req_i && !ack_o && cnt >= wait_i) begin
            cnt <= 4'h0;
            ack_o <= 1'b1;
            ack_vec_o <= vec_i;
        end else begin
            cnt <= inta_req_i ? cnt + 4'h1 : 4'h0;
            ack_o <= 1'b0;
            ack_vec_o <= ~ack_vec_o;
        end
    end

    // ready is read before the edge it is taken on; call 1 ns after an edge
    task automatic send_msg(input logic [7:0] v);
        logic r;
        valid_o = 1'b1;
        msg_o = v;
        do begin
            @(negedge clk_i);
            r = ready_i;
            @(posedge clk_i);
        end while (r !== 1'b1);
        #1;
        valid_o = 1'b0;
        msg_o = ~v;
    endtask
endmodule

// ### tb/interrupt_source_vectoring_tb_top.sv
// testbench: exception map, soft, nmi, maskable and router paths
`timescale 1ns/10ps

module interrupt_source_vectoring_tb_top;
    import isv_pkg::*;
    logic clk = 0, rst_n = 0, lic = 0, ien = 0, sreq = 0, ereq = 0, done = 0, crdy = 1;
    logic [1:0] pins = 2'b00;
    logic [7:0] svec = 8'h00, evec = 8'h00, mvec = 8'h00;
    logic [3:0] mwait = 4'h0;
    isv_vtab_t vtab0 = '0, vtab1 = '0;
    logic rv, rr, ireq, iack, evalid, illg, rsvd, nact;
    logic [7:0] rvec, ivec;
    isv_event_t ev;
    int n_fail = 0, check_count = 0, i;
    // vector, class, pushes code, code is zero
    logic [11:0] rows [13] = '{
        {VEC_DIVIDE_ERROR, ISV_CLS_FAULT, 2'b00}, {VEC_BREAKPOINT, ISV_CLS_TRAP, 2'b00},
        {VEC_OVERFLOW, ISV_CLS_TRAP, 2'b00}, {VEC_BOUND_RANGE, ISV_CLS_FAULT, 2'b00},
        {VEC_INVALID_OPCODE, ISV_CLS_FAULT, 2'b00}, {VEC_COPROC_UNAVAIL, ISV_CLS_FAULT, 2'b00},
        {VEC_DOUBLE_FAULT, ISV_CLS_ABORT, 2'b11}, {8'h0A, ISV_CLS_FAULT, 2'b10},
        {8'h0E, ISV_CLS_FAULT, 2'b10}, {VEC_X87_MATH, ISV_CLS_FAULT, 2'b00},
        {VEC_ALIGN_CHECK, ISV_CLS_FAULT, 2'b11}, {VEC_SIMD_FLOAT, ISV_CLS_FAULT, 2'b00},
        {VEC_MACHINE_CHECK, ISV_CLS_ABORT, MC_PUSHES_ERRCODE, 1'b0}};
    logic [7:0] rsv [4] = '{8'h09, 8'h0F, 8'h14, 8'h1F};

    always #4 clk = ~clk;

    isv_vectoring isv_vectoring_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .LOCAL_INT_I(pins),
        .LIC_EN_I(lic), .VTAB0_I(vtab0), .VTAB1_I(vtab1), .ROUTER_VALID_I(rv), .ROUTER_VEC_I(rvec),
        .ROUTER_READY_O(rr), .INTA_REQ_O(ireq), .INTA_ACK_I(iack), .INTA_VEC_I(ivec),
        .INT_ENABLE_I(ien), .SOFT_REQ_I(sreq), .SOFT_VEC_I(svec), .EXC_REQ_I(ereq),
        .EXC_VEC_I(evec), .NMI_DONE_I(done), .CORE_READY_I(crdy), .EVT_VALID_O(evalid),
        .EVT_O(ev), .ILLEGAL_VEC_O(illg), .RSVD_VEC_O(rsvd), .NMI_ACTIVE_O(nact));

    isv_ctrl_model isv_ctrl_model_inst (.clk_i(clk), .rst_n_i(rst_n), .inta_req_i(ireq),
        .ready_i(rr), .vec_i(mvec), .wait_i(mwait), .ack_o(iack), .ack_vec_o(ivec),
        .valid_o(rv), .msg_o(rvec));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // bounded wait on an output bit, then check it rose
    task automatic wait_hi(input string nm, ref logic s);
        for (int k = 0; k < 20 && s !== 1'b1; k++) step();
        chk(nm, 8'h01, s);
    endtask

    task automatic evt(input isv_source_t s, input logic [7:0] v, input logic nh);
        wait_hi("evt_valid", evalid);
        sreq = 0;
        ereq = 0;
        chk("evt_src", s, ev.source);
        chk("evt_vec", v, ev.vector);
        chk("evt_nmi_hw", nh, ev.nmi_hw);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        final_report();
    end

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        #1;
        chk("rst_valid", 8'h00, evalid);
        chk("rst_inta", 8'h00, ireq);
        chk("rst_ready", 8'h01, rr);
        rst_n = 1;
        step();
        foreach (rows[i]) begin
            evec = rows[i][11:4];
            ereq = 1;
            evt(ISV_SRC_EXCEPTION, rows[i][11:4], 1'b0);
            chk("cls", rows[i][3:2], ev.cls);
            chk("push_err", rows[i][1], ev.push_err);
            if (rows[i][0]) chk("err_zero", 8'h01, ev.err_zero);
            step();
        end
        foreach (rsv[i]) begin
            evec = rsv[i];
            ereq = 1;
            wait_hi("rsvd", rsvd);
            ereq = 0;
            chk("rsvd_no_evt", 8'h00, evalid);
            step();
        end
        // soft interrupts with the enable flag low
        for (i = 0; i < 4; i++) begin
            svec = i[1] ? {i[0], 7'h23} : {6'h00, i[0], 1'b0};
            sreq = 1;
            evt(ISV_SRC_SOFT, svec, 1'b0);
            step();
        end
        chk("soft_nmi_state", 8'h00, nact);
        // core stalls: event must stand until taken
        crdy = 0;
        svec = 8'h30;
        sreq = 1;
        evt(ISV_SRC_SOFT, 8'h30, 1'b0);
        repeat (3) step();
        chk("stall_hold", 8'h01, evalid);
        chk("stall_vec", 8'h30, ev.vector);
        crdy = 1;
        step();
        chk("stall_release", 8'h00, evalid);
        pins = 2'b10;
        evt(ISV_SRC_NMI, VEC_NMI, 1'b1);
        step();
        chk("nmi_active", 8'h01, nact);
        pins = 2'b01;
        done = 1;
        step();
        done = 0;
        repeat (10) step();
        chk("masked_inta", 8'h00, ireq);
        chk("masked_evt", 8'h00, evalid);
        chk("nmi_clear", 8'h00, nact);
        for (i = 0; i < 2; i++) begin
            mvec = i[0] ? 8'hC8 : 8'h05;
            mwait = i[0] ? 4'h0 : 4'h3;
            pins = 2'b01;
            ien = 1;
            wait_hi("inta_req", ireq);
            pins = 2'b00;
            evt(ISV_SRC_MASKABLE, mvec, 1'b0);
            step();
        end
        lic = 1;
        ien = 0;
        isv_ctrl_model_inst.send_msg(8'h41);
        repeat (5) step();
        chk("router_masked", 8'h00, evalid);
        ien = 1;
        evt(ISV_SRC_LOCAL, 8'h41, 1'b0);
        step();
        isv_ctrl_model_inst.send_msg(8'h0F);
        wait_hi("illegal", illg);
        chk("illegal_no_evt", 8'h00, evalid);
        vtab0 = '{nmi_mode: 1'b0, masked: 1'b0, vector: 8'h50};
        vtab1 = '{nmi_mode: 1'b1, masked: 1'b0, vector: 8'h00};
        pins = 2'b01;
        evt(ISV_SRC_LOCAL, 8'h50, 1'b0);
        pins = 2'b10;
        step();
        evt(ISV_SRC_NMI, VEC_NMI, 1'b1);
        step();
        // masked entry: a pin edge must raise nothing; stalled core keeps any stray event visible
        crdy = 0;
        vtab0 = '{nmi_mode: 1'b0, masked: 1'b1, vector: 8'h50};
        pins = 2'b11;
        repeat (6) step();
        chk("masked_entry", 8'h00, evalid);
        chk("masked_ready", 8'h01, rr);
        final_report();
    end
endmodule
